//--- ecr_pkg.sv
// shared constants and types for the reload-type event counter channel
package ecr_pkg;

  localparam int unsigned ECR_COUNT_WIDTH = 16;
  localparam int unsigned ECR_PIN_COUNT   = 2;
  localparam int unsigned ECR_PIN_EVENT   = 0;
  localparam int unsigned ECR_PIN_DIR     = 1;

  localparam logic [ECR_COUNT_WIDTH-1:0] ECR_COUNT_RESET  = 16'h0000;
  localparam logic [ECR_COUNT_WIDTH-1:0] ECR_RELOAD_RESET = 16'h0000;
  localparam logic [ECR_COUNT_WIDTH-1:0] ECR_COUNT_MAX    = 16'hffff;

  typedef enum logic [1:0] {
    ECR_SRC_PIN_FALL = 2'h0,
    ECR_SRC_PIN_RISE = 2'h1,
    ECR_SRC_OVERFLOW = 2'h2
  } ecr_src_t;

  typedef enum logic {
    ECR_OVF_B_TIMER_TWO = 1'b0,
    ECR_OVF_NEIGHBOUR   = 1'b1
  } ecr_ovf_sel_t;

  typedef enum logic {
    ECR_DIR_FROM_FLAG = 1'b0,
    ECR_DIR_FROM_PIN  = 1'b1
  } ecr_dir_sel_t;

  typedef enum logic {
    ECR_STOPPED = 1'b0,
    ECR_RUNNING = 1'b1
  } ecr_state_t;

  // software control bits of the channel
  typedef struct packed {
    logic         startFlag;
    ecr_src_t     srcSel;
    ecr_ovf_sel_t ovfSel;
    ecr_dir_sel_t dirSel;
    logic         upFlag;
  } ecr_cfg_t;

endpackage

//--- ecr_pin_sync.sv
// two-flop synchroniser with edge detection for the channel pins
module ecr_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] prev_q;

  // only stage2_q reads stage1_q
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // pins idle high, so leaving reset makes no false edge
      stage1_q <= '1;
      stage2_q <= '1;
      prev_q   <= '1;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      prev_q   <= stage2_q;
    end
  end

  assign level = stage2_q;
  assign rise  = stage2_q & ~prev_q;
  assign fall  = ~stage2_q & prev_q;

endmodule

//--- ecr_event_counter.sv
// reload-type event counter channel with pin or timer-overflow count source
//
// Contract
// - start flag one counts falling or rising pin edges or overflow pulses, as selected
// - underflow reloads, keeps counting, sets request
// - overflow reloads, keeps counting, sets request
// - direction change applies at next edge
// - start flag zero stops and holds value
// - overflow source: b timer two or neighbour
// - direction from up flag or pin level
module ecr_event_counter
  import ecr_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = ECR_COUNT_WIDTH
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire ecr_cfg_t               cfg,
  input  wire logic                   reloadWe,
  input  wire logic [COUNT_WIDTH-1:0] reloadData,
  input  wire logic                   irqClear,
  input  wire logic                   eventInputPin,
  input  wire logic                   directionInputPin,
  input  wire logic                   bTimerTwoOvf,
  input  wire logic                   neighbourOvf,
  output logic      [COUNT_WIDTH-1:0] countValue,
  output logic                        irqReq,
  output logic                        overflowPulse,
  output logic                        running
);

  localparam logic [COUNT_WIDTH-1:0] CNT_ZERO = '0;
  localparam logic [COUNT_WIDTH-1:0] CNT_ONE  = COUNT_WIDTH'(1);
  localparam logic [COUNT_WIDTH-1:0] CNT_MAX  = '1;

  ecr_state_t             state_q;
  logic [COUNT_WIDTH-1:0] countValue_q;
  logic [COUNT_WIDTH-1:0] reloadValue_q;
  logic                   irqReq_q;
  logic                   overflowPulse_q;

  logic [ECR_PIN_COUNT-1:0] pinLevel;
  logic [ECR_PIN_COUNT-1:0] pinRise;
  logic [ECR_PIN_COUNT-1:0] pinFall;

  logic srcEdge;
  logic ovfSource;
  logic countDown;
  logic countEvent;
  logic wrapEvent;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  ecr_pin_sync #(
    .WIDTH (ECR_PIN_COUNT)
  ) u_pin_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   ({directionInputPin, eventInputPin}),
    .level   (pinLevel),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // count source and direction selection

  assign ovfSource = (cfg.ovfSel == ECR_OVF_NEIGHBOUR) ? neighbourOvf : bTimerTwoOvf;

  always_comb begin
    srcEdge = 1'b0;
    unique case (cfg.srcSel)
      ECR_SRC_PIN_FALL: srcEdge = pinFall[ECR_PIN_EVENT];
      ECR_SRC_PIN_RISE: srcEdge = pinRise[ECR_PIN_EVENT];
      ECR_SRC_OVERFLOW: srcEdge = ovfSource;
      default:          srcEdge = 1'b0;
    endcase
  end

  assign countDown = (cfg.dirSel == ECR_DIR_FROM_PIN) ? !pinLevel[ECR_PIN_DIR] : !cfg.upFlag;

  assign countEvent = (state_q == ECR_RUNNING) && srcEdge;
  assign wrapEvent  = countEvent &&
                      (countDown ? (countValue_q == CNT_ZERO) : (countValue_q == CNT_MAX));

  //////////////////////////////////////////////////////////////////////////////
  // run control

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ECR_STOPPED;
    end else begin
      unique case (state_q)
        ECR_STOPPED: if (cfg.startFlag) begin
          state_q <= ECR_RUNNING;
        end
        ECR_RUNNING: if (!cfg.startFlag) begin
          state_q <= ECR_STOPPED;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reload register

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reloadValue_q <= ECR_RELOAD_RESET;
    end else if (reloadWe) begin
      reloadValue_q <= reloadData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      countValue_q <= ECR_COUNT_RESET;
    end else if (wrapEvent) begin
      countValue_q <= reloadValue_q;
    end else if (countEvent) begin
      countValue_q <= countDown ? countValue_q - CNT_ONE : countValue_q + CNT_ONE;
    end else if (reloadWe && state_q == ECR_STOPPED) begin
      // preset while stopped
      countValue_q <= reloadData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt request and overflow output

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqReq_q <= 1'b0;
    end else if (wrapEvent) begin
      irqReq_q <= 1'b1;
    end else if (irqClear) begin
      irqReq_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overflowPulse_q <= 1'b0;
    end else begin
      overflowPulse_q <= wrapEvent;
    end
  end

  assign countValue    = countValue_q;
  assign irqReq        = irqReq_q;
  assign overflowPulse = overflowPulse_q;
  assign running       = (state_q == ECR_RUNNING);

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  AST_START_RUNS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_q == ECR_STOPPED && cfg.startFlag) |=> (state_q == ECR_RUNNING)
  ) else $error("start flag did not start the counter");

  AST_UP_COUNT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (countEvent && !countDown && countValue_q != CNT_MAX)
      |=> (countValue_q == $past(countValue_q) + CNT_ONE)
  ) else $error("up count edge did not increment");

  AST_UNDERFLOW_RELOAD: assert property (
    @(posedge clk) disable iff (!reset_n)
    (countEvent && countDown && countValue_q == CNT_ZERO)
      |=> (countValue_q == $past(reloadValue_q)) && irqReq_q && overflowPulse_q
  ) else $error("underflow did not reload and request");

  AST_OVERFLOW_RELOAD: assert property (
    @(posedge clk) disable iff (!reset_n)
    (countEvent && !countDown && countValue_q == CNT_MAX)
      |=> (countValue_q == $past(reloadValue_q)) && irqReq_q && (state_q == ECR_RUNNING)
  ) else $error("overflow did not reload and continue");

  AST_DOWN_COUNT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (countEvent && countDown && countValue_q != CNT_ZERO)
      |=> (countValue_q == $past(countValue_q) - CNT_ONE)
  ) else $error("down count edge did not decrement");

  AST_STOP_HOLDS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!cfg.startFlag && !reloadWe) [*2] |=> $stable(countValue_q)
  ) else $error("stopped counter changed value");

  AST_NEIGHBOUR_SOURCE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (cfg.srcSel == ECR_SRC_OVERFLOW && state_q == ECR_RUNNING &&
     (cfg.ovfSel == ECR_OVF_NEIGHBOUR ? neighbourOvf : bTimerTwoOvf))
      |=> (countValue_q != $past(countValue_q)) || overflowPulse_q
  ) else $error("selected overflow source not counted");

  AST_OVF_UNSELECTED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (cfg.srcSel == ECR_SRC_OVERFLOW && state_q == ECR_RUNNING &&
     !(cfg.ovfSel == ECR_OVF_NEIGHBOUR ? neighbourOvf : bTimerTwoOvf))
      |=> $stable(countValue_q)
  ) else $error("unselected overflow source was counted");

  AST_DIR_PIN: assert property (
    @(posedge clk) disable iff (!reset_n)
    (countEvent && cfg.dirSel == ECR_DIR_FROM_PIN &&
     countValue_q != CNT_ZERO && countValue_q != CNT_MAX)
      |=> (countValue_q == ($past(pinLevel[ECR_PIN_DIR]) ? $past(countValue_q) + CNT_ONE
                                                          : $past(countValue_q) - CNT_ONE))
  ) else $error("pin direction not followed");

  AST_IRQ_STICKY: assert property (
    @(posedge clk) disable iff (!reset_n)
    (irqReq_q && !irqClear) |=> irqReq_q
  ) else $error("request dropped without clear");

  AST_IRQ_CLEARS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (irqClear && !wrapEvent) |=> !irqReq_q
  ) else $error("request not cleared");

  AST_STOPPED_IGNORES: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_q == ECR_STOPPED && !reloadWe) |=> $stable(countValue_q)
  ) else $error("stopped counter counted an edge");

endmodule

//--- ecr_src_model.sv
// partner model: external event pin and timer overflow pulse sources
module ecr_src_model (
  input  wire logic clk,
  output logic      eventPin,
  output logic      bOvf,
  output logic      nOvf
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    eventPin = 1'b1;
    bOvf = 1'b0;
    nOvf = 1'b0;
  end

  ////////////////////////////////////////
  // low pulse, each level held two clocks or more
  task automatic pinPulse(input int lowCyc);
    @(negedge clk);
    eventPin = 1'b0;
    repeat (lowCyc) @(negedge clk);
    eventPin = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // one-cycle overflow pulse of the b timer two or of the neighbour
  task automatic ovfPulse(input logic toNeighbour);
    @(negedge clk);
    nOvf = toNeighbour;
    bOvf = !toNeighbour;
    @(negedge clk);
    nOvf = 1'b0;
    bOvf = 1'b0;
  endtask
endmodule

//--- tb_top.sv
// self-checking testbench of the reload-type event counter channel
module tb_top
  import ecr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  ecr_cfg_t    cfg = '0;
  logic        reloadWe = 1'b0;
  logic [15:0] reloadData = 16'h0000;
  logic        irqClear = 1'b0;
  logic        dirPin = 1'b1;
  logic        eventPin, bOvf, nOvf, irqReq, overflowPulse, running;
  logic [15:0] countValue;
  logic [16:0] q[$];
  logic [16:0] note;
  logic [15:0] expCnt = 16'h0000;
  logic [15:0] reloadExp = 16'h0000;
  logic [15:0] prevCnt = 16'h0000;
  logic        expIrq = 1'b0;
  logic [31:0] r;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  int          seed = 29824;
  int          wraps = 0;
  int          pulses = 0;

  ecr_src_model src (.clk(clk), .eventPin(eventPin), .bOvf(bOvf), .nOvf(nOvf));

  ecr_event_counter uut (
    .clk(clk), .reset_n(reset_n), .cfg(cfg), .reloadWe(reloadWe),
    .reloadData(reloadData), .irqClear(irqClear), .eventInputPin(eventPin),
    .directionInputPin(dirPin), .bTimerTwoOvf(bOvf), .neighbourOvf(nOvf),
    .countValue(countValue), .irqReq(irqReq), .overflowPulse(overflowPulse),
    .running(running)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(string what, logic [16:0] e, logic [16:0] s);
    compares++;
    if (e !== s) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // every count change takes the oldest note, or the previous count if none is queued
  always @(negedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end else if (reset_n) begin
      if (overflowPulse === 1'b1) pulses++;
      if (countValue !== prevCnt) begin
        note = (q.size() > 0) ? q.pop_front() : {expIrq, prevCnt};
        check("count", note, {irqReq, countValue});
        prevCnt = countValue;
      end
    end
  end

  ////////////////////////////////////////
  task automatic step(logic up);
    logic [15:0] old;
    old = expCnt;
    if (up ? old == 16'hffff : old == 16'h0000) begin
      expCnt = reloadExp;
      expIrq = 1'b1;
      wraps++;
    end else begin
      expCnt = up ? old + 16'h0001 : old - 16'h0001;
    end
    if (expCnt != old) q.push_back({expIrq, expCnt});
  endtask

  task automatic reload(logic [15:0] v);
    reloadData = v;
    reloadWe = 1'b1;
    reloadExp = v;
    if (!cfg.startFlag && v != expCnt) q.push_back({expIrq, v});
    if (!cfg.startFlag) expCnt = v;
    @(negedge clk);
    reloadWe = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // kind 0 pin pulse, 1 b timer two, 2 neighbour
  task automatic evt(int kind);
    if (cfg.startFlag && (kind == 0 ? cfg.srcSel inside {ECR_SRC_PIN_FALL, ECR_SRC_PIN_RISE} :
        cfg.srcSel == ECR_SRC_OVERFLOW && int'(cfg.ovfSel) == kind - 1)) begin
      step(cfg.dirSel ? dirPin : cfg.upFlag);
    end
    if (kind == 0) src.pinPulse(2 + {$random(seed)} % 3);
    else src.ovfPulse(kind == 2);
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    check("reset", 17'h0, {irqReq | running, countValue});
    reset_n = 1'b1;
    reload(16'h0002);
    evt(0);
    cfg.startFlag = 1'b1;
    repeat (3) @(negedge clk);
    check("running", 17'h1, {16'h0, running});
    repeat (3) evt(0);
    cfg.upFlag = 1'b1;
    evt(0);
    cfg.startFlag = 1'b0;
    repeat (2) @(negedge clk);
    reload(16'hfffe);
    cfg.startFlag = 1'b1;
    repeat (2) evt(0);
    cfg.dirSel = ECR_DIR_FROM_PIN;
    dirPin = 1'b0;
    repeat (3) @(negedge clk);
    evt(0);
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      cfg = ecr_cfg_t'(r[5:0]);
      dirPin = r[6];
      if (r[9:7] == 3'h0) begin
        irqClear = 1'b1;
        expIrq = 1'b0;
      end
      @(negedge clk);
      irqClear = 1'b0;
      repeat (3) @(negedge clk);
      if (r[12:10] == 3'h0) reload(r[13] ? {14'h0, r[15:14]} : {14'h3fff, r[15:14]});
      evt({r[31:16]} % 3);
    end
    cfg.startFlag = 1'b0;
    repeat (3) @(negedge clk);
    evt(0);
    check("stopped", 17'h0, {16'h0, running});
    check("pending", 17'h0, 17'(q.size()));
    check("wraps", 17'(wraps), 17'(pulses));
    conclude();
  end
endmodule
